/* logic/avrp_defs.svh */
/*
  Constants of the residual output packer: record sizes, field positions and fill codes.
  Assumes it is included by bare name from the packer's design files.
*/
`ifndef AVRP_DEFS_SVH
`define AVRP_DEFS_SVH

// ***************************************************
// weight and offset record
// ***************************************************
`define AVRP_WO_LAST 4'hF
`define AVRP_RSV_COMP 2'h3

// ***************************************************
// coefficient and sample dwords
// ***************************************************
`define AVRP_MBZ_BITS 9'h000
`define AVRP_PCM_LAST 2'h3
`define AVRP_CNT_W 16

// ***************************************************
// reference index dwords
// ***************************************************
`define AVRP_NIB_NONE 4'hF
`define AVRP_REF_FILL 32'hFFFFFFFF
`define AVRP_REF_SLOTS 4

`endif

/* logic/avrp_pkg.sv */
/*
  Types of the residual output packer: partition shapes, word kinds, block order,
  the per-macroblock command, the data beat and the output word.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none

package avrp_pkg;

  typedef enum logic [1:0] {AVRP_P16X16, AVRP_P16X8, AVRP_P8X16, AVRP_P8X8} avrp_part_t;
  typedef enum logic [1:0] {AVRP_K_WO, AVRP_K_COEF, AVRP_K_PCM, AVRP_K_REF} avrp_kind_t;
  typedef enum logic [3:0] {
    BLK_LUMA_DC, BLK_Y0, BLK_Y1, BLK_Y2, BLK_Y3, BLK_CB_DC, BLK_CR_DC, BLK_CB, BLK_CR, BLK_NONE
  } avrp_blk_t;

  typedef struct packed {
    logic [7:0] weight;
    logic [7:0] offset;
  } avrp_wo_t;

  typedef struct packed {
    logic raw_pixel;
    logic whole_mb_intra_mode;
    logic cb_dc;
    logic cr_dc;
    logic second_used;
    avrp_part_t part;
    logic [3:0] pred_first;
    logic [3:0] pred_second;
    avrp_wo_t [3:0][2:0] wo_first;
    avrp_wo_t [3:0][2:0] wo_second;
    logic [3:0][3:0] ref_first;
    logic [3:0] ref_first_ok;
    logic [3:0][3:0] ref_second;
    logic [3:0] ref_second_ok;
  } avrp_mb_cmd_t;

  typedef struct packed {
    logic [15:0] value;
    logic [5:0] index;
    logic last;
  } avrp_din_t;

  typedef struct packed {
    avrp_kind_t kind;
    logic [31:0] word;
  } avrp_word_t;

endpackage : avrp_pkg

`default_nettype wire

/* logic/avrp_buf.sv */
/*
  Two-entry buffer between the packer and the memory writer; all outputs are flops.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ns
`default_nettype none

module avrp_buf #(
  parameter int WIDTH = 34
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  logic v1_q;
  logic [WIDTH-1:0] d1_q;
  logic push;
  logic pop;

  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // head always sits in out_data so the output needs no mux
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      out_valid <= 1'b0;
      out_data <= '0;
      v1_q <= 1'b0;
      d1_q <= '0;
      in_ready <= 1'b1;
    end else if (pop) begin
      if (v1_q) begin
        out_data <= d1_q;
        v1_q <= 1'b0;
        in_ready <= 1'b1;
      end else if (push) begin
        out_data <= in_data;
      end else begin
        out_valid <= 1'b0;
      end
    end else if (push) begin
      if (!out_valid) begin
        out_data <= in_data;
        out_valid <= 1'b1;
      end else begin
        d1_q <= in_data;
        v1_q <= 1'b1;
        in_ready <= 1'b0;
      end
    end
  end

endmodule : avrp_buf

`default_nettype wire

/* logic/avrp_packer.sv */
/*
  Residual output packer: turns one macroblock command plus a beat stream of
  coefficients or raw samples into weight/offset, coefficient, sample and
  reference-index dwords for the inverse transform stage.
  Assumes the producer supplies beats for the block shown on coef_blk and that
  a memory writer drains out_word by kind.
*/
`timescale 1ns/1ns
`default_nettype none
`include "avrp_defs.svh"

// Operation
// (RULE1) non-16x16 weights laid out as four slots
// (RULE2) tall-narrow partition copied into stacked slots
// (RULE3) wide-short partition copied into adjacent slots
// (RULE4) four 8x8 partitions each own slot
// (RULE5) weight high byte; first list low half
// (RULE6) first entry falls back to second, else zero
// (RULE7) second entry falls back to first, else zero
// (RULE8) slot is three entries plus reserved dword
// (RULE9) fourth slot ends sixteen-dword record, zero reserved
// (RULE10) coefficients normally, raw samples in raw mode
// (RULE11) only non-zero coefficients, fixed block order
// (RULE12) intra 16x16 starts with luma DC
// (RULE13) value in upper half, bits 15:7 zero
// (RULE14) six-bit raster index of coefficient
// (RULE15) end flag only on block's last coefficient
// (RULE16) producer clamps coefficients to twelve bits
// (RULE17) dword aligned output, length in dwords
// (RULE18) raw mode packs four samples per dword
// (RULE19) four-bit reference, all ones means none
// (RULE20) eight reference nibbles per dword; code fills four, upper four all ones
// (RULE21) lists separate; none raw, none unused second
// (RULE22) references in raster block order
module avrp_packer (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // macroblock command
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire avrp_pkg::avrp_mb_cmd_t cmd,
  // coefficient or sample beats
  input wire logic din_valid,
  output logic din_ready,
  input wire avrp_pkg::avrp_din_t din,
  output var avrp_pkg::avrp_blk_t coef_blk,
  // packed dwords
  output logic out_valid,
  input wire logic out_ready,
  output var avrp_pkg::avrp_word_t out_word,
  // macroblock status
  output logic mb_done,
  output logic [`AVRP_CNT_W-1:0] mb_dword_cnt
);
  import avrp_pkg::*;

  typedef enum logic [2:0] {ST_IDLE, ST_WO, ST_COEF, ST_FLUSH, ST_PCM, ST_REF} avrp_state_t;

  avrp_state_t st_q;
  avrp_mb_cmd_t cmd_q;
  logic [3:0] wo_cnt_q;
  logic list_q;
  logic pend_q;
  avrp_word_t pend_word_q;
  logic held_q;
  logic [15:0] held_val_q;
  logic [5:0] held_idx_q;
  logic [23:0] pcm_acc_q;
  logic [1:0] pcm_cnt_q;
  logic [`AVRP_CNT_W-1:0] run_cnt_q;
  logic buf_rdy;
  logic slot_free;
  logic take_cmd;
  logic take_din;
  logic new_v;
  avrp_word_t new_w;
  logic pend_d;
  logic end_mb;
  logic data_w;

  // ***************************************************
  // decoding helpers
  // ***************************************************
  function automatic logic [1:0] wo_part(avrp_part_t part, logic [1:0] slot);
    unique case (part)
      AVRP_P16X16: wo_part = 2'h0;
      AVRP_P16X8: wo_part = {1'b0, slot[1]}; // RULE3
      AVRP_P8X16: wo_part = {1'b0, slot[0]}; // RULE2
      AVRP_P8X8: wo_part = slot; // RULE4
    endcase
  endfunction : wo_part

  function automatic logic [15:0] wo_pick(logic own_ok, logic other_ok, avrp_wo_t own_v, avrp_wo_t other_v);
    wo_pick = own_ok ? own_v : (other_ok ? other_v : 16'h0000); // RULE6 RULE7
  endfunction : wo_pick

  function automatic logic [31:0] wo_word(avrp_mb_cmd_t c, logic [3:0] n);
    logic [1:0] p;
    logic [1:0] k;
    wo_word = 32'h00000000;
    p = wo_part(c.part, n[3:2]); // RULE1
    k = n[1:0];
    if (k != `AVRP_RSV_COMP) begin // RULE8 RULE9
      wo_word = {wo_pick(c.pred_second[p], c.pred_first[p], c.wo_second[p][k], c.wo_first[p][k]),
                 wo_pick(c.pred_first[p], c.pred_second[p], c.wo_first[p][k], c.wo_second[p][k])}; // RULE5
    end
  endfunction : wo_word

  function automatic avrp_blk_t blk_next(avrp_mb_cmd_t c, avrp_blk_t b);
    unique case (b)
      BLK_NONE: blk_next = c.whole_mb_intra_mode ? BLK_LUMA_DC : BLK_Y0; // RULE12
      BLK_LUMA_DC: blk_next = BLK_Y0;
      BLK_Y0: blk_next = BLK_Y1;
      BLK_Y1: blk_next = BLK_Y2;
      BLK_Y2: blk_next = BLK_Y3;
      BLK_Y3: blk_next = c.cb_dc ? BLK_CB_DC : (c.cr_dc ? BLK_CR_DC : BLK_CB); // RULE11
      BLK_CB_DC: blk_next = c.cr_dc ? BLK_CR_DC : BLK_CB;
      BLK_CR_DC: blk_next = BLK_CB;
      BLK_CB: blk_next = BLK_CR;
      BLK_CR: blk_next = BLK_NONE;
      default: blk_next = BLK_NONE;
    endcase
  endfunction : blk_next

  function automatic logic [31:0] coef_word(logic [15:0] v, logic [5:0] idx, logic end_of_block_flag);
    coef_word = {v, `AVRP_MBZ_BITS, idx, end_of_block_flag}; // RULE13 RULE14
  endfunction : coef_word

  function automatic logic [31:0] ref_word(logic [3:0][3:0] r, logic [3:0] ok);
    ref_word = `AVRP_REF_FILL;
    for (int i = 0; i < `AVRP_REF_SLOTS; i++) begin
      ref_word[4*i +: 4] = ok[i] ? r[i] : `AVRP_NIB_NONE; // RULE19 RULE20 RULE22
    end
  endfunction : ref_word

  function automatic logic [31:0] pcm_word(logic [23:0] acc, logic [1:0] cnt, logic [7:0] smp);
    pcm_word = {8'h00, acc};
    pcm_word[8*cnt +: 8] = smp; // RULE18
  endfunction : pcm_word

  assign slot_free = !pend_q | buf_rdy;
  assign take_cmd = cmd_valid & cmd_ready;
  assign take_din = din_valid & din_ready;

  // ***************************************************
  // word generation
  // ***************************************************
  always_comb begin
    new_v = 1'b0;
    new_w = '0;
    unique case (st_q)
      ST_IDLE: begin
      end
      ST_WO: begin
        new_v = slot_free;
        new_w = {AVRP_K_WO, wo_word(cmd_q, wo_cnt_q)};
      end
      ST_COEF: begin
        // zeros are dropped; a held word is sent once a later non-zero proves it is not last
        new_v = take_din && din.value != 16'h0000 && held_q; // RULE11
        new_w = {AVRP_K_COEF, coef_word(held_val_q, held_idx_q, 1'b0)};
      end
      ST_FLUSH: begin
        new_v = slot_free && held_q;
        new_w = {AVRP_K_COEF, coef_word(held_val_q, held_idx_q, 1'b1)}; // RULE15
      end
      ST_PCM: begin
        new_v = take_din && (pcm_cnt_q == `AVRP_PCM_LAST || din.last);
        new_w = {AVRP_K_PCM, pcm_word(pcm_acc_q, pcm_cnt_q, din.value[7:0])};
      end
      ST_REF: begin
        new_v = slot_free;
        new_w = {AVRP_K_REF, list_q ? ref_word(cmd_q.ref_second, cmd_q.ref_second_ok)
                                    : ref_word(cmd_q.ref_first, cmd_q.ref_first_ok)}; // RULE21
      end
    endcase
    pend_d = (pend_q & !buf_rdy) | new_v;
    end_mb = (st_q == ST_PCM && take_din && din.last) ||
             (st_q == ST_REF && slot_free && (list_q || !cmd_q.second_used));
    data_w = new_v && (st_q == ST_COEF || st_q == ST_FLUSH || st_q == ST_PCM);
  end

  // ***************************************************
  // sequencing
  // ***************************************************
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st_q <= ST_IDLE;
      cmd_ready <= 1'b1;
      wo_cnt_q <= 4'h0;
      list_q <= 1'b0;
      coef_blk <= BLK_NONE;
    end else begin
      unique case (st_q)
        ST_IDLE: begin
          if (take_cmd) begin
            cmd_ready <= 1'b0;
            wo_cnt_q <= 4'h0;
            list_q <= 1'b0;
            st_q <= cmd.raw_pixel ? ST_PCM : ST_WO; // RULE10
          end
        end
        ST_WO: begin
          if (slot_free) begin
            wo_cnt_q <= wo_cnt_q + 4'h1;
            if (wo_cnt_q == `AVRP_WO_LAST) begin // RULE9
              st_q <= ST_COEF;
              coef_blk <= blk_next(cmd_q, BLK_NONE); // RULE12
            end
          end
        end
        ST_COEF: begin
          if (take_din && din.last) begin
            st_q <= ST_FLUSH;
          end
        end
        ST_FLUSH: begin
          if (slot_free) begin
            coef_blk <= blk_next(cmd_q, coef_blk); // RULE11
            st_q <= (blk_next(cmd_q, coef_blk) == BLK_NONE) ? ST_REF : ST_COEF;
          end
        end
        ST_PCM: begin
          // raw macroblocks carry no reference indices
          if (take_din && din.last) begin // RULE21
            st_q <= ST_IDLE;
            cmd_ready <= 1'b1;
          end
        end
        ST_REF: begin
          if (slot_free) begin
            if (list_q || !cmd_q.second_used) begin // RULE21
              st_q <= ST_IDLE;
              cmd_ready <= 1'b1;
              coef_blk <= BLK_NONE;
            end else begin
              list_q <= 1'b1;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cmd_q <= '0;
    end else if (take_cmd) begin
      cmd_q <= cmd;
    end
  end

  // registered ready costs one bubble per word but keeps the port a flop
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      din_ready <= 1'b0;
    end else begin
      din_ready <= !pend_d && (st_q == ST_COEF || st_q == ST_PCM) && !(take_din && din.last);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      held_q <= 1'b0;
      held_val_q <= 16'h0000;
      held_idx_q <= 6'h00;
    end else if (st_q == ST_COEF && take_din && din.value != 16'h0000) begin
      held_q <= 1'b1;
      held_val_q <= din.value;
      held_idx_q <= din.index; // RULE14
    end else if (st_q == ST_FLUSH && slot_free) begin
      held_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pcm_acc_q <= 24'h000000;
      pcm_cnt_q <= 2'h0;
    end else if (st_q == ST_PCM && take_din) begin
      if (pcm_cnt_q == `AVRP_PCM_LAST || din.last) begin
        pcm_acc_q <= 24'h000000;
        pcm_cnt_q <= 2'h0;
      end else begin
        pcm_acc_q[8*pcm_cnt_q +: 8] <= din.value[7:0]; // RULE18
        pcm_cnt_q <= pcm_cnt_q + 2'h1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pend_q <= 1'b0;
      pend_word_q <= '0;
    end else begin
      pend_q <= pend_d;
      if (new_v) begin
        pend_word_q <= new_w;
      end
    end
  end

  // ***************************************************
  // macroblock length
  // ***************************************************
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      run_cnt_q <= '0;
      mb_dword_cnt <= '0;
      mb_done <= 1'b0;
    end else begin
      mb_done <= end_mb;
      if (take_cmd) begin
        run_cnt_q <= '0;
      end else if (data_w) begin
        run_cnt_q <= run_cnt_q + `AVRP_CNT_W'(1);
      end
      if (end_mb) begin
        mb_dword_cnt <= run_cnt_q + `AVRP_CNT_W'(data_w); // RULE17
      end
    end
  end

  avrp_buf #(.WIDTH($bits(avrp_word_t))) u_buf (
    .clk_sys(clk_sys),
    .reset(reset),
    .in_valid(pend_q),
    .in_ready(buf_rdy),
    .in_data(pend_word_q),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_data(out_word)
  );

  // ***************************************************
  // checks
  // ***************************************************
  AST_WO_RESERVED: assert property (@(posedge clk_sys) disable iff (reset) // RULE9
    st_q == ST_WO && slot_free && wo_cnt_q[1:0] == 2'h3 |=> pend_q && pend_word_q.word == 32'h0)
    else $error("reserved weight dword not zero");
  AST_WO_WIDE: assert property (@(posedge clk_sys) disable iff (reset) // RULE3
    st_q == ST_WO && slot_free && cmd_q.part == AVRP_P16X8 && wo_cnt_q[3:2] == 2'h1
    |=> pend_word_q.word == wo_word(cmd_q, {2'h0, $past(wo_cnt_q[1:0])}))
    else $error("wide partition slot one differs from slot zero");
  AST_WO_TALL: assert property (@(posedge clk_sys) disable iff (reset) // RULE2
    st_q == ST_WO && slot_free && cmd_q.part == AVRP_P8X16 && wo_cnt_q[3:2] == 2'h2
    |=> pend_word_q.word == wo_word(cmd_q, {2'h0, $past(wo_cnt_q[1:0])}))
    else $error("tall partition slot two differs from slot zero");
  AST_WO_OWN: assert property (@(posedge clk_sys) disable iff (reset) // RULE4 RULE5 RULE6
    st_q == ST_WO && slot_free && cmd_q.part == AVRP_P8X8 && wo_cnt_q[1:0] != 2'h3
    && cmd_q.pred_first[wo_cnt_q[3:2]]
    |=> pend_word_q.word[15:0] == $past(cmd_q.wo_first[wo_cnt_q[3:2]][wo_cnt_q[1:0]]))
    else $error("first list entry not taken from own partition");
  AST_WO_SECOND: assert property (@(posedge clk_sys) disable iff (reset) // RULE7
    st_q == ST_WO && slot_free && cmd_q.part == AVRP_P8X8 && wo_cnt_q[1:0] != 2'h3
    && !cmd_q.pred_second[wo_cnt_q[3:2]] && cmd_q.pred_first[wo_cnt_q[3:2]]
    |=> pend_word_q.word[31:16] == $past(cmd_q.wo_first[wo_cnt_q[3:2]][wo_cnt_q[1:0]]))
    else $error("second list entry did not fall back");
  AST_COEF_SHAPE: assert property (@(posedge clk_sys) disable iff (reset) // RULE11 RULE13
    pend_q && pend_word_q.kind == AVRP_K_COEF |-> pend_word_q.word[31:16] != 16'h0 && pend_word_q.word[15:7] == 9'h0)
    else $error("bad coefficient dword");
  AST_FIRST_BLOCK: assert property (@(posedge clk_sys) disable iff (reset) // RULE12
    st_q == ST_WO && slot_free && wo_cnt_q == 4'hF
    |=> coef_blk == (cmd_q.whole_mb_intra_mode ? BLK_LUMA_DC : BLK_Y0))
    else $error("wrong first block");
  AST_EOB_MID: assert property (@(posedge clk_sys) disable iff (reset) // RULE15
    st_q == ST_COEF && take_din && din.value != 16'h0 && held_q |=> pend_q && !pend_word_q.word[0])
    else $error("end flag on inner coefficient");
  AST_EOB_END: assert property (@(posedge clk_sys) disable iff (reset) // RULE15
    st_q == ST_FLUSH && slot_free && held_q |=> pend_q && pend_word_q.word[0] && !held_q)
    else $error("end flag missing on last coefficient");
  AST_RAW_PATH: assert property (@(posedge clk_sys) disable iff (reset) // RULE10 RULE21
    take_cmd && cmd.raw_pixel |=> st_q == ST_PCM ##1 st_q != ST_WO && st_q != ST_REF)
    else $error("raw macroblock left sample path");
  AST_PCM_PACK: assert property (@(posedge clk_sys) disable iff (reset) // RULE18
    st_q == ST_PCM && take_din && pcm_cnt_q == 2'h3 |=> pend_word_q.word[31:24] == $past(din.value[7:0]))
    else $error("fourth sample misplaced");
  AST_REF_NONE: assert property (@(posedge clk_sys) disable iff (reset) // RULE19 RULE20
    st_q == ST_REF && slot_free && !list_q && !cmd_q.ref_first_ok[0]
    |=> pend_word_q.word[3:0] == 4'hF && pend_word_q.word[31:16] == 16'hFFFF)
    else $error("missing reference not all ones");

endmodule : avrp_packer

`default_nettype wire

/* testbench/avrp_mem_model.sv */
/*
  Memory side of the packer: drains packed dwords into a queue, stalling on request.
  Assumes one clock and a synchronous active-high reset shared with the packer.
*/
`timescale 1ns/1ns
`default_nettype none

module avrp_mem_model (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // packed dwords
  input wire logic out_valid,
  output var logic out_ready,
  input wire avrp_pkg::avrp_word_t out_word,
  // test control
  input wire logic stall_en
);
  import avrp_pkg::*;
  avrp_word_t got_q[$];
  logic [1:0] phase_q = 2'h0;
  logic [15:0] addr_q = 16'h0000;

  // ***************************************************
  // acceptance, slow when stalling
  // ***************************************************
  always @(posedge clk_sys) begin
    phase_q <= reset ? 2'h0 : ((phase_q == 2'h2) ? 2'h0 : phase_q + 2'h1);
    out_ready <= !reset && (!stall_en || phase_q == 2'h1);
  end

  // whole dwords only, so the buffer length is a dword count
  always @(posedge clk_sys) begin
    if (!reset && out_valid && out_ready) begin
      got_q.push_back(out_word);
      addr_q <= addr_q + 16'h0001;
    end
  end
endmodule : avrp_mem_model

`default_nettype wire

/* testbench/avrp_packer_test.sv */
/*
  Self-checking bench of the residual output packer, one task per scenario.
  Assumes the packer, its buffer and the memory model are compiled before it.
*/
`timescale 1ns/1ns
`default_nettype none
`include "avrp_defs.svh"

module avrp_packer_test;
  import avrp_pkg::*;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic cmd_valid = 1'b0;
  logic cmd_ready;
  avrp_mb_cmd_t cmd = '0;
  logic din_valid = 1'b0;
  logic din_ready;
  avrp_din_t din = '0;
  avrp_blk_t coef_blk;
  logic out_valid;
  logic out_ready;
  avrp_word_t out_word;
  logic mb_done;
  logic [`AVRP_CNT_W-1:0] mb_dword_cnt;
  logic stall_en = 1'b0;
  int err_count = 0;
  int cmp_count = 0;
  avrp_word_t exp_q[$];

  always #5 clk_sys = ~clk_sys;

  avrp_packer avrp_packer_inst (.clk_sys(clk_sys), .reset(reset), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd(cmd), .din_valid(din_valid), .din_ready(din_ready), .din(din),
    .coef_blk(coef_blk), .out_valid(out_valid), .out_ready(out_ready), .out_word(out_word),
    .mb_done(mb_done), .mb_dword_cnt(mb_dword_cnt));
  avrp_mem_model avrp_mem_model_inst (.clk_sys(clk_sys), .reset(reset), .out_valid(out_valid),
    .out_ready(out_ready), .out_word(out_word), .stall_en(stall_en));

  // ***************************************************
  // comparison and verdict
  // ***************************************************
  task automatic check(input logic [63:0] got, input logic [63:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check

  task automatic print_verdict();
    if (err_count == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : print_verdict

  // ***************************************************
  // expected values
  // ***************************************************
  function automatic logic [15:0] pick(avrp_mb_cmd_t c, int p, int m, bit sec);
    if (sec ? c.pred_second[p] : c.pred_first[p]) return sec ? c.wo_second[p][m] : c.wo_first[p][m];
    if (sec ? c.pred_first[p] : c.pred_second[p]) return sec ? c.wo_first[p][m] : c.wo_second[p][m];
    return 16'h0000;
  endfunction : pick

  function automatic logic [31:0] exp_wo(avrp_mb_cmd_t c, int d);
    int s;
    int p;
    s = d / 4;
    case (c.part)
      AVRP_P16X8: p = s / 2;
      AVRP_P8X16: p = s % 2;
      AVRP_P8X8: p = s;
      default: p = 0;
    endcase
    if (d % 4 == 3) return 32'h00000000;
    return {pick(c, p, d % 4, 1'b1), pick(c, p, d % 4, 1'b0)};
  endfunction : exp_wo

  function automatic logic [31:0] exp_ref(logic [3:0][3:0] r, logic [3:0] ok);
    logic [15:0] v;
    for (int i = 0; i < 4; i++) v[4*i +: 4] = ok[i] ? r[i] : 4'hF;
    return {16'hFFFF, v};
  endfunction : exp_ref

  // producer side keeps every value inside the signed twelve-bit range
  function automatic logic [15:0] beat_val(avrp_blk_t b, int k);
    if (b == BLK_Y2 || k == 1) return 16'h0000;
    if (k == 0) return 16'h0010 + 16'(b);
    return b[0] ? 16'hFF00 + 16'(b) : 16'h0000;
  endfunction : beat_val

  function automatic logic coef_eob(avrp_blk_t b, int k);
    for (int j = k + 1; j < 3; j++) if (beat_val(b, j) != 16'h0000) return 1'b0;
    return 1'b1;
  endfunction : coef_eob

  function automatic avrp_din_t make_beat(logic raw, avrp_blk_t b, int k);
    logic dc;
    dc = (b == BLK_LUMA_DC || b == BLK_CB_DC || b == BLK_CR_DC);
    if (raw) return {8'h00, 8'((k == 2) ? 0 : 8'hA1 + 19 * k), 6'h00, k == 6};
    return {beat_val(b, k), dc ? 6'(k) : 6'h3F - 6'(k), k == 2};
  endfunction : make_beat

  function automatic avrp_mb_cmd_t mk_cmd(avrp_part_t part, logic [3:0] pf, logic [3:0] ps);
    avrp_mb_cmd_t c;
    c = '0;
    c.part = part;
    c.pred_first = pf;
    c.pred_second = ps;
    for (int p = 0; p < 4; p++) begin
      for (int m = 0; m < 3; m++) begin
        c.wo_first[p][m] = 16'(16'h1101 + 16'h1000 * p + 16'h0110 * m);
        c.wo_second[p][m] = 16'(16'h8A05 + 16'h0800 * p + 16'h0020 * m);
      end
    end
    c.ref_first = 16'h3210;
    c.ref_second = 16'h7654;
    c.ref_first_ok = 4'hF;
    c.ref_second_ok = 4'hF;
    return c;
  endfunction : mk_cmd

  // ***************************************************
  // one macroblock: offer, feed, drain, compare
  // ***************************************************
  task automatic run_mb(input avrp_mb_cmd_t c);
    avrp_blk_t b;
    avrp_blk_t blk_q[$];
    avrp_word_t got_q[$];
    logic [31:0] acc;
    int k, g, cnt;
    bit fed, done;
    logic [15:0] a0;
    exp_q.delete();
    avrp_mem_model_inst.got_q.delete();
    a0 = avrp_mem_model_inst.addr_q;
    acc = '0;
    k = 0;
    cnt = 0;
    fed = 0;
    done = 0;
    b = BLK_NONE;
    if (!c.raw_pixel) begin
      for (int d = 0; d < 16; d++) exp_q.push_back({AVRP_K_WO, exp_wo(c, d)});
      if (c.whole_mb_intra_mode) blk_q.push_back(BLK_LUMA_DC);
      blk_q = {blk_q, BLK_Y0, BLK_Y1, BLK_Y2, BLK_Y3};
      if (c.cb_dc) blk_q.push_back(BLK_CB_DC);
      if (c.cr_dc) blk_q.push_back(BLK_CR_DC);
      blk_q = {blk_q, BLK_CB, BLK_CR};
    end
    cmd <= c;
    cmd_valid <= 1'b1;
    g = 0;
    do begin
      @(posedge clk_sys);
      g++;
    end while (!cmd_ready && g < 50);
    cmd_valid <= 1'b0;
    for (g = 0; g < 3000; g++) begin
      @(posedge clk_sys);
      if (mb_done) begin
        done = 1;
        check(mb_dword_cnt, cnt, "dword count");
        break;
      end
      if (din_valid && din_ready) begin
        if (c.raw_pixel) begin
          acc[8*(k%4) +: 8] = din.value[7:0];
          if (k % 4 == 3 || din.last) begin
            exp_q.push_back({AVRP_K_PCM, acc});
            acc = '0;
            cnt++;
          end
        end else if (din.value != 16'h0000) begin
          exp_q.push_back({AVRP_K_COEF, din.value, 9'h000, din.index, coef_eob(b, k)});
          cnt++;
        end
        k++;
        if (din.last) begin
          din_valid <= 1'b0;
          fed = c.raw_pixel;
          k = 0;
        end else begin
          din <= make_beat(c.raw_pixel, b, k);
        end
      end else if (!din_valid && din_ready && !fed && (c.raw_pixel || coef_blk != BLK_NONE)) begin
        b = coef_blk;
        if (!c.raw_pixel) check(b, blk_q.pop_front(), "block order");
        din <= make_beat(c.raw_pixel, b, 0);
        din_valid <= 1'b1;
      end
    end
    check(done, 1'b1, "macroblock end");
    check(blk_q.size(), 0, "blocks left");
    if (!c.raw_pixel) begin
      exp_q.push_back({AVRP_K_REF, exp_ref(c.ref_first, c.ref_first_ok)});
      if (c.second_used) exp_q.push_back({AVRP_K_REF, exp_ref(c.ref_second, c.ref_second_ok)});
    end
    for (g = 0; g < 500 && avrp_mem_model_inst.got_q.size() < exp_q.size(); g++) @(negedge clk_sys);
    @(negedge clk_sys);
    check(out_valid, 1'b0, "extra dwords");
    got_q = avrp_mem_model_inst.got_q;
    check(got_q.size(), exp_q.size(), "word count");
    check(16'(avrp_mem_model_inst.addr_q - a0), exp_q.size(), "dword address");
    foreach (exp_q[i]) begin
      case (exp_q[i].kind)
        AVRP_K_WO: check(got_q[i], exp_q[i], "weight dword");
        AVRP_K_COEF: check(got_q[i], exp_q[i], "coef dword");
        AVRP_K_PCM: check(got_q[i], exp_q[i], "sample dword");
        default: check(got_q[i], exp_q[i], "reference dword");
      endcase
    end
    @(posedge clk_sys);
  endtask : run_mb

  // ***************************************************
  // scenarios
  // ***************************************************
  task automatic t_reset_state();
    check({cmd_ready, din_ready, out_valid, mb_done, coef_blk, mb_dword_cnt}, {4'b1000, BLK_NONE, 16'h0}, "idle");
  endtask : t_reset_state

  task automatic t_tall_narrow();
    avrp_mb_cmd_t c;
    c = mk_cmd(AVRP_P8X16, 4'b0001, 4'b0010);
    c.second_used = 1'b1;
    c.ref_second_ok = 4'b1011;
    stall_en <= 1'b1;
    run_mb(c);
  endtask : t_tall_narrow

  task automatic t_wide_short();
    avrp_mb_cmd_t c;
    c = mk_cmd(AVRP_P16X8, 4'b0011, 4'b0001);
    c.cb_dc = 1'b1;
    c.ref_first_ok = 4'b0110;
    stall_en <= 1'b0;
    run_mb(c);
  endtask : t_wide_short

  task automatic t_quad();
    avrp_mb_cmd_t c;
    c = mk_cmd(AVRP_P8X8, 4'b0101, 4'b1100);
    c.cr_dc = 1'b1;
    c.second_used = 1'b1;
    stall_en <= 1'b1;
    run_mb(c);
  endtask : t_quad

  task automatic t_intra();
    avrp_mb_cmd_t c;
    c = mk_cmd(AVRP_P16X16, 4'b0000, 4'b0000);
    c.whole_mb_intra_mode = 1'b1;
    c.cb_dc = 1'b1;
    c.cr_dc = 1'b1;
    stall_en <= 1'b0;
    run_mb(c);
  endtask : t_intra

  task automatic t_raw();
    avrp_mb_cmd_t c;
    c = mk_cmd(AVRP_P16X16, 4'b0001, 4'b0001);
    c.raw_pixel = 1'b1;
    c.second_used = 1'b1;
    stall_en <= 1'b1;
    run_mb(c);
  endtask : t_raw

  // a hang is cut off after 40000 cycles, far more than the scenarios need
  initial begin
    #400000;
    err_count++;
    print_verdict();
  end

  initial begin
    repeat (12) @(posedge clk_sys);
    reset <= 1'b0;
    @(negedge clk_sys);
    t_reset_state();
    @(posedge clk_sys);
    t_tall_narrow();
    t_wide_short();
    t_quad();
    t_intra();
    t_raw();
    print_verdict();
  end
endmodule : avrp_packer_test

`default_nettype wire
